// *** core/slsr_top.sv ***
// serial link status register with ahb-lite slave and link sampling
`timescale 1ns/1ns
`include "slsr_cfg.svh"
module slsr_top (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // link side, sampled on link_clk_i rising edges
  input  wire logic        link_clk_i,
  input  wire logic [3:0]  link_rx_lanes_i,
  input  wire logic [3:0]  link_tx_lanes_i,
  input  wire logic [2:0]  link_sample_i,
  input  wire logic        link_flow_on_i,
  input  wire logic        link_flow_off_i,
  input  wire logic        link_err_symbol_i,
  input  wire logic        link_pkt_error_i,
  input  wire logic        link_init_done_i,
  input  wire logic        link_timeout_i,
  // core side, same clock
  input  wire logic        fifo1_full_i,
  input  wire logic        fifo2_full_i,
  input  wire logic [3:0]  fifo_not_empty_i,
  input  wire logic        slave_pend_i,
  input  wire logic        master_pend_i,
  // outputs
  output logic             tx_stall_o,
  output logic             outbound_flow_request_o,
  output logic             port_interrupt_o
);
  import slsr_pkg::*;

  // ************************************************************
  // functions
  // ************************************************************
  // reserved lane codes are shown as no lanes
  function automatic logic [3:0] lane_ok(input logic [3:0] code);
    lane_ok = (code <= `SLSR_LANE_MAX) ? code : `SLSR_LANE_NONE;
  endfunction

  // register select, shared by the write strobes and the read check
  function automatic logic reg_hit(input logic [`SLSR_ADDR_W-1:0] addr,
                                   input logic [`SLSR_ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction

  // ************************************************************
  // link sampling
  // ************************************************************
  logic [`SLSR_SW_W-1:0] link_async;
  logic [`SLSR_SW_W-1:0] link_sync;
  logic                  link_strobe;
  logic [`SLSR_LW_W-1:0] link_word;

  assign link_async = {link_clk_i, link_timeout_i, link_init_done_i, link_pkt_error_i,
                       link_err_symbol_i, link_flow_off_i, link_flow_on_i,
                       link_sample_i, link_tx_lanes_i, link_rx_lanes_i};

  slsr_sync u_sync (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .async_i    (link_async),
    .sync_o     (link_sync)
  );

  slsr_edge u_edge (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .sync_i     (link_sync),
    .strobe_o   (link_strobe),
    .word_o     (link_word)
  );

  logic ev_flow_on;
  logic ev_flow_off;
  logic ev_rem;
  logic ev_loc;
  logic ev_init;
  logic ev_timeout;

  assign ev_flow_on  = link_strobe & link_word[`SLSR_LW_FLOW_ON];
  assign ev_flow_off = link_strobe & link_word[`SLSR_LW_FLOW_OFF];
  assign ev_rem      = link_strobe & link_word[`SLSR_LW_ERR_SYM];
  assign ev_loc      = link_strobe & link_word[`SLSR_LW_PKT_ERR];
  assign ev_init     = link_strobe & link_word[`SLSR_LW_INIT_DONE];
  assign ev_timeout  = link_strobe & link_word[`SLSR_LW_TIMEOUT];

  // ************************************************************
  // state
  // ************************************************************
  slsr_state_type s;
  slsr_state_type next_s;
  logic           addr_take;
  logic           wr_status;
  logic           wr_mask;
  logic [31:0]    status_word;

  assign addr_take = hsel_i & htrans_i[`SLSR_HTRANS_ACT] & hready_i;
  assign wr_status = s.dp_valid & s.dp_write & reg_hit(s.dp_addr, `SLSR_OFF_STATUS);
  assign wr_mask   = s.dp_valid & s.dp_write & reg_hit(s.dp_addr, `SLSR_OFF_MASK);

  always_comb begin
    status_word = `SLSR_WORD_ZERO;
    status_word[`SLSR_RX_LANE_MSB:`SLSR_RX_LANE_LSB] = s.rx_lanes;
    status_word[`SLSR_TX_LANE_MSB:`SLSR_TX_LANE_LSB] = s.tx_lanes;
    status_word[`SLSR_SAMPLE_MSB:`SLSR_SAMPLE_LSB]   = s.sample;
    status_word[`SLSR_RTM_BIT]     = `SLSR_RTM_PRESENT;
    status_word[`SLSR_INBOUND_FLOW_STALL_BIT]   = s.in_flow;
    status_word[`SLSR_OUTBOUND_FLOW_REQUEST_BIT]   = s.out_flow;
    status_word[`SLSR_REM_ERR_BIT] = s.rem_err;
    status_word[`SLSR_LOC_ERR_BIT] = s.loc_err;
    status_word[`SLSR_NEMPTY_MSB:`SLSR_NEMPTY_LSB] = fifo_not_empty_i;
    status_word[`SLSR_SPEND_BIT]   = slave_pend_i;
    status_word[`SLSR_MPEND_BIT]   = master_pend_i;
    status_word[`SLSR_LINK_BIT]    = (s.link == SLSR_LINK_UP);
  end

  always_comb begin
    next_s = s;
    // bus: zero wait states, read data registered in the address phase
    next_s.hreadyout = 1'b1;
    next_s.hresp     = `SLSR_RESP_OKAY;
    next_s.dp_valid  = addr_take;
    next_s.dp_write  = hwrite_i;
    next_s.dp_addr   = haddr_i[`SLSR_ADDR_W-1:0];
    next_s.hrdata    = `SLSR_WORD_ZERO;
    if (addr_take && !hwrite_i) begin
      unique case (haddr_i[`SLSR_ADDR_W-1:0])
        `SLSR_OFF_STATUS: begin
          next_s.hrdata = status_word;
        end
        `SLSR_OFF_MASK: begin
          next_s.hrdata[`SLSR_REM_ERR_BIT] = s.mask_rem;
          next_s.hrdata[`SLSR_LOC_ERR_BIT] = s.mask_loc;
        end
        default: begin
          next_s.hrdata = `SLSR_WORD_ZERO;
        end
      endcase
    end
    // link sampled fields change only on a link edge, never by software
    if (link_strobe) begin
      next_s.rx_lanes = lane_ok(link_word[`SLSR_LW_RX_MSB:`SLSR_LW_RX_LSB]);
      next_s.tx_lanes = lane_ok(link_word[`SLSR_LW_TX_MSB:`SLSR_LW_TX_LSB]);
      next_s.sample   = link_word[`SLSR_LW_SMP_MSB:`SLSR_LW_SMP_LSB];
    end
    // an enable in the same sample as a disable keeps the stall
    if (ev_flow_on) begin
      next_s.in_flow = 1'b1;
    end else if (ev_flow_off) begin
      next_s.in_flow = 1'b0;
    end
    next_s.out_flow = fifo1_full_i | fifo2_full_i;
    // a new error in the clearing cycle wins over the clear
    next_s.rem_err = (s.rem_err & ~(wr_status & hwdata_i[`SLSR_REM_ERR_BIT])) | ev_rem;
    next_s.loc_err = (s.loc_err & ~(wr_status & hwdata_i[`SLSR_LOC_ERR_BIT])) | ev_loc;
    if (wr_mask) begin
      next_s.mask_rem = hwdata_i[`SLSR_REM_ERR_BIT];
      next_s.mask_loc = hwdata_i[`SLSR_LOC_ERR_BIT];
    end
    // timeout drops the link even if done is seen in the same sample
    if (ev_timeout) begin
      next_s.link = SLSR_LINK_DOWN;
    end else if (ev_init) begin
      next_s.link = SLSR_LINK_UP;
    end
    next_s.irq = (next_s.rem_err & next_s.mask_rem) | (next_s.loc_err & next_s.mask_loc);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= SLSR_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign hrdata_o                = s.hrdata;
  assign hreadyout_o             = s.hreadyout;
  assign hresp_o                 = s.hresp;
  assign tx_stall_o              = s.in_flow;
  assign outbound_flow_request_o = s.out_flow;
  assign port_interrupt_o        = s.irq;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  logic rd_status;
  assign rd_status = s.dp_valid & ~s.dp_write & reg_hit(s.dp_addr, `SLSR_OFF_STATUS);

  rtm_reads_one_a: assert property (
    rd_status |-> hrdata_o[`SLSR_RTM_BIT])
    else $error("presence bit read as zero");

  reserved_zero_a: assert property (
    rd_status |-> (hrdata_o[`SLSR_RES_HI_MSB:`SLSR_RES_HI_LSB] == 4'h0)
                  && (hrdata_o[`SLSR_RES_LO_MSB:`SLSR_RES_LO_LSB] == 5'h00))
    else $error("reserved status bits not zero");

  w1c_clear_a: assert property (
    (wr_status && hwdata_i[`SLSR_REM_ERR_BIT] && !ev_rem) |=> !s.rem_err)
    else $error("remote error not cleared by write one");

  w0_holds_a: assert property (
    (wr_status && !hwdata_i[`SLSR_LOC_ERR_BIT] && s.loc_err) |=> s.loc_err)
    else $error("local error lost on write zero");

  rem_set_a: assert property (
    ev_rem |=> s.rem_err && (!s.mask_rem || port_interrupt_o))
    else $error("error symbol did not set remote flag");

  loc_set_a: assert property (
    (ev_loc && s.mask_loc && !wr_mask) |=> s.loc_err && port_interrupt_o)
    else $error("packet error did not raise interrupt");

  irq_masked_a: assert property (
    (!s.mask_rem && !s.mask_loc) |-> !port_interrupt_o)
    else $error("interrupt with all masks off");

  stall_on_a: assert property (
    ev_flow_on |=> tx_stall_o)
    else $error("flow enable did not stall");

  stall_off_a: assert property (
    (ev_flow_off && !ev_flow_on) |=> !tx_stall_o)
    else $error("flow disable did not resume");

  outbound_flow_request_track_a: assert property (
    ##1 outbound_flow_request_o == $past(fifo1_full_i | fifo2_full_i))
    else $error("outbound flow request not following fifo full");

  lane_report_a: assert property (
    (link_strobe && link_word[`SLSR_LW_RX_MSB:`SLSR_LW_RX_LSB] <= `SLSR_LANE_MAX)
    |=> s.rx_lanes == $past(link_word[`SLSR_LW_RX_MSB:`SLSR_LW_RX_LSB]))
    else $error("receive lane count not reported");

  tx_lane_res_a: assert property (
    (link_strobe && link_word[`SLSR_LW_TX_MSB:`SLSR_LW_TX_LSB] > `SLSR_LANE_MAX)
    |=> s.tx_lanes == `SLSR_LANE_NONE)
    else $error("reserved transmit lane code shown");

  read_only_a: assert property (
    (wr_status && !link_strobe) |=> $stable(s.rx_lanes) && $stable(s.sample))
    else $error("software write changed read-only field");

  link_down_a: assert property (
    ev_timeout |=> (s.link == SLSR_LINK_DOWN) [*2])
    else $error("link stayed up after timeout");

  link_up_a: assert property (
    (ev_init && !ev_timeout) |=> s.link == SLSR_LINK_UP)
    else $error("link not up after init done");

  loc_w1c_a: assert property (
    (wr_status && hwdata_i[`SLSR_LOC_ERR_BIT] && !ev_loc) |=> !s.loc_err)
    else $error("local error not cleared by write one");

  rem_w0_a: assert property (
    (wr_status && !hwdata_i[`SLSR_REM_ERR_BIT] && s.rem_err) |=> s.rem_err)
    else $error("remote error lost on write zero");

  rem_cause_a: assert property (
    (!ev_rem && !s.rem_err) |=> !s.rem_err)
    else $error("remote error set without error symbol");

  loc_cause_a: assert property (
    (!ev_loc && !s.loc_err) |=> !s.loc_err)
    else $error("local error set without packet error");

  sample_track_a: assert property (
    link_strobe |=> s.sample == $past(link_word[`SLSR_LW_SMP_MSB:`SLSR_LW_SMP_LSB]))
    else $error("sample select not reported");

  rx_lane_res_a: assert property (
    (link_strobe && link_word[`SLSR_LW_RX_MSB:`SLSR_LW_RX_LSB] > `SLSR_LANE_MAX)
    |=> s.rx_lanes == `SLSR_LANE_NONE)
    else $error("reserved receive lane code shown");

  cov_rem_irq: cover property (ev_rem ##[1:4] port_interrupt_o);
  cov_link_up: cover property (ev_init ##1 s.link == SLSR_LINK_UP);
  cov_stall:   cover property (ev_flow_on ##[1:50] ev_flow_off);
  cov_clear:   cover property (s.rem_err ##1 (wr_status && hwdata_i[`SLSR_REM_ERR_BIT]));
endmodule

// *** core/slsr_cfg.svh ***
// constants of the serial link status register block
`ifndef SLSR_CFG_SVH
`define SLSR_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SLSR_ADDR_W          8
`define SLSR_OFF_STATUS      8'h00
`define SLSR_OFF_MASK        8'h04
`define SLSR_HTRANS_ACT      1

// ************************************************************
// link_status field positions
// ************************************************************
`define SLSR_RX_LANE_MSB     27
`define SLSR_RX_LANE_LSB     24
`define SLSR_TX_LANE_MSB     23
`define SLSR_TX_LANE_LSB     20
`define SLSR_SAMPLE_MSB      14
`define SLSR_SAMPLE_LSB      12
`define SLSR_RTM_BIT         11
`define SLSR_INBOUND_FLOW_STALL_BIT       10
`define SLSR_OUTBOUND_FLOW_REQUEST_BIT       9
`define SLSR_REM_ERR_BIT     8
`define SLSR_LOC_ERR_BIT     7
`define SLSR_NEMPTY_MSB      6
`define SLSR_NEMPTY_LSB      3
`define SLSR_SPEND_BIT       2
`define SLSR_MPEND_BIT       1
`define SLSR_LINK_BIT        0
`define SLSR_RES_HI_MSB      31
`define SLSR_RES_HI_LSB      28
`define SLSR_RES_LO_MSB      19
`define SLSR_RES_LO_LSB      15

// ************************************************************
// values
// ************************************************************
`define SLSR_LANE_MAX        4'h4
`define SLSR_LANE_NONE       4'h0
`define SLSR_RTM_PRESENT     1'h1
`define SLSR_WORD_ZERO       32'h0000_0000
`define SLSR_RESP_OKAY       1'h0

// ************************************************************
// sampled link word layout
// ************************************************************
`define SLSR_LW_W            17
`define SLSR_SW_W            18
`define SLSR_LW_RX_MSB       3
`define SLSR_LW_RX_LSB       0
`define SLSR_LW_TX_MSB       7
`define SLSR_LW_TX_LSB       4
`define SLSR_LW_SMP_MSB      10
`define SLSR_LW_SMP_LSB      8
`define SLSR_LW_FLOW_ON      11
`define SLSR_LW_FLOW_OFF     12
`define SLSR_LW_ERR_SYM      13
`define SLSR_LW_PKT_ERR      14
`define SLSR_LW_INIT_DONE    15
`define SLSR_LW_TIMEOUT      16
`define SLSR_SW_CLK          17

`endif

// *** core/slsr_pkg.sv ***
// types of the serial link status register block
`include "slsr_cfg.svh"
package slsr_pkg;

  typedef enum logic [0:0] {
    SLSR_LINK_DOWN = 1'b0,
    SLSR_LINK_UP   = 1'b1
  } slsr_link_type;

  typedef struct packed {
    logic [`SLSR_SW_W-1:0] stage1;
    logic [`SLSR_SW_W-1:0] stage2;
  } slsr_sync_type;

  typedef struct packed {
    logic                  prev_clk;
    logic                  strobe;
    logic [`SLSR_LW_W-1:0] word;
  } slsr_edge_type;

  typedef struct packed {
    logic [3:0]             rx_lanes;
    logic [3:0]             tx_lanes;
    logic [2:0]             sample;
    logic                   in_flow;
    logic                   out_flow;
    logic                   rem_err;
    logic                   loc_err;
    slsr_link_type          link;
    logic                   mask_rem;
    logic                   mask_loc;
    logic                   irq;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    logic                   dp_valid;
    logic                   dp_write;
    logic [`SLSR_ADDR_W-1:0] dp_addr;
  } slsr_state_type;

  parameter slsr_state_type SLSR_STATE_RESET = '{
    link:      SLSR_LINK_DOWN,
    hreadyout: 1'b1,
    default:   '0
  };

endpackage

// *** core/slsr_sync.sv ***
// two flip-flop synchroniser for the link clock and link signals
`timescale 1ns/1ns
`include "slsr_cfg.svh"
module slsr_sync (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // asynchronous inputs
  input  wire logic [`SLSR_SW_W-1:0] async_i,
  // synchronised outputs
  output logic      [`SLSR_SW_W-1:0] sync_o
);
  import slsr_pkg::*;

  slsr_sync_type s;
  slsr_sync_type next_s;

  // stage1 is read only by stage2
  always_comb begin
    next_s        = s;
    next_s.stage1 = async_i;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.stage2;
endmodule

// *** core/slsr_edge.sv ***
// finds rising edges of the synchronised link clock and captures the link word
`timescale 1ns/1ns
`include "slsr_cfg.svh"
module slsr_edge (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  // synchronised link side
  input  wire logic [`SLSR_SW_W-1:0] sync_i,
  // captured word
  output logic                       strobe_o,
  output logic      [`SLSR_LW_W-1:0] word_o
);
  import slsr_pkg::*;

  slsr_edge_type s;
  slsr_edge_type next_s;
  logic          rise;

  // data and clock share the same two-stage delay, so the word is stable here
  always_comb begin
    next_s          = s;
    rise            = sync_i[`SLSR_SW_CLK] & ~s.prev_clk;
    next_s.prev_clk = sync_i[`SLSR_SW_CLK];
    next_s.strobe   = rise;
    if (rise) begin
      next_s.word = sync_i[`SLSR_LW_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign strobe_o = s.strobe;
  assign word_o   = s.word;
endmodule

// *** tb/slsr_peer.sv ***
// behavioural peer link controller driving the sampled link pins
`timescale 1ns/1ns
module slsr_peer (
  // link clock
  output logic       link_clk_o,
  // link levels and one-sample events
  output logic [3:0] rx_lanes_o,
  output logic [3:0] tx_lanes_o,
  output logic [2:0] sample_o,
  output logic [5:0] event_o
);
  // ****************
  // one link frame
  // ****************
  // clock stands low between frames; data moves only while it is low
  task automatic send(input logic [3:0] rx, input logic [3:0] tx, input logic [2:0] smp,
                      input logic [5:0] ev, input int gap);
    #(gap + 7);
    rx_lanes_o = rx;
    tx_lanes_o = tx;
    sample_o   = smp;
    event_o    = ev;
    #80 link_clk_o = 1'h1;
    #80 link_clk_o = 1'h0;
    // events are single pulses, so they drop once the rise is past
    event_o    = 6'h00;
  endtask

  initial begin
    link_clk_o = 1'h0;
    rx_lanes_o = 4'h0;
    tx_lanes_o = 4'h0;
    sample_o   = 3'h0;
    event_o    = 6'h00;
  end
endmodule

// *** tb/serial_link_status_register_test.sv ***
// self-checking bench of the serial link status register block
`timescale 1ns/1ns
`include "slsr_cfg.svh"
module serial_link_status_register_test;
  // ****************
  // signals
  // ****************
  logic        core_clk_i, nrst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, seed, rd;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i, link_smp, ls;
  logic        link_clk, fifo1_full_i, fifo2_full_i, slave_pend_i, master_pend_i;
  logic [3:0]  link_rx, link_tx, fifo_not_empty_i, lr, lt;
  logic [5:0]  link_ev, ev;
  logic        tx_stall_o, outbound_flow_request_o, port_interrupt_o;
  int          fail_count, samples_checked, cycles;
  int          m_rx, m_tx, m_smp, m_stall, m_rerr, m_lerr, m_link, m_mask;

  slsr_top dut_u (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hready_i(hreadyout_o),
    .hwdata_i(hwdata_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .link_clk_i(link_clk), .link_rx_lanes_i(link_rx), .link_tx_lanes_i(link_tx),
    .link_sample_i(link_smp), .link_flow_on_i(link_ev[5]), .link_flow_off_i(link_ev[4]),
    .link_err_symbol_i(link_ev[3]), .link_pkt_error_i(link_ev[2]),
    .link_init_done_i(link_ev[1]), .link_timeout_i(link_ev[0]),
    .fifo1_full_i(fifo1_full_i), .fifo2_full_i(fifo2_full_i),
    .fifo_not_empty_i(fifo_not_empty_i), .slave_pend_i(slave_pend_i),
    .master_pend_i(master_pend_i), .tx_stall_o(tx_stall_o),
    .outbound_flow_request_o(outbound_flow_request_o), .port_interrupt_o(port_interrupt_o)
  );

  slsr_peer peer_u (
    .link_clk_o(link_clk), .rx_lanes_o(link_rx), .tx_lanes_o(link_tx),
    .sample_o(link_smp), .event_o(link_ev)
  );

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd(input logic [31:0] s);
    for (int i = 0; i < 32; i++) begin
      s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    end
    return s;
  endfunction

  function automatic logic [31:0] exp_status();
    return {4'h0, 4'(m_rx), 4'(m_tx), 5'h00, 3'(m_smp), 1'h1, 1'(m_stall),
            fifo1_full_i | fifo2_full_i, 1'(m_rerr), 1'(m_lerr), fifo_not_empty_i,
            slave_pend_i, master_pend_i, 1'(m_link)};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // single word transfer; waits on the slave's ready, never on a fixed count
  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge core_clk_i);
    hsel_i   <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h000000, addr};
    hwrite_i <= wr;
    do @(negedge core_clk_i); while (hreadyout_o !== 1'h1);
    @(posedge core_clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(negedge core_clk_i); while (hreadyout_o !== 1'h1);
    rdv = hrdata_o;
    check("hresp", {31'h0, hresp_o}, 32'h0);
    @(posedge core_clk_i);
  endtask

  // ****************
  // clock, reset, timeout
  // ****************
  initial begin
    core_clk_i = 1'h0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // a hang shows up as a missing ready; ceiling far above the expected run
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ****************
  // main sequence
  // ****************
  initial begin
    {nrst_i, hsel_i, hwrite_i, fifo1_full_i, fifo2_full_i} = 5'h00;
    {slave_pend_i, master_pend_i, htrans_i, fifo_not_empty_i} = 8'h00;
    haddr_i  = 32'h0;
    hwdata_i = 32'h0;
    hsize_i  = 3'h2;
    seed     = 32'hc7be4987;
    {m_rx, m_tx, m_smp, m_stall, m_rerr, m_lerr, m_link, m_mask} = '0;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'h1;
    ahb(1'h0, `SLSR_OFF_STATUS, 32'h0, rd);
    check("status reset", rd, 32'h0000_0800);
    ahb(1'h1, `SLSR_OFF_STATUS, 32'hffff_ffff, rd);
    ahb(1'h0, `SLSR_OFF_STATUS, 32'h0, rd);
    check("status ro", rd, 32'h0000_0800);
    ahb(1'h1, 8'h10, 32'hffff_ffff, rd);
    ahb(1'h0, 8'h10, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    for (int it = 0; it < 90; it++) begin
      seed = rnd(seed);
      @(posedge core_clk_i);
      fifo1_full_i     <= seed[0] & seed[1];
      fifo2_full_i     <= seed[2] & seed[3];
      fifo_not_empty_i <= seed[7:4];
      slave_pend_i     <= seed[8];
      master_pend_i    <= seed[9];
      ev = {seed[10], seed[11], seed[12] & seed[13], seed[14] & seed[15], seed[16],
            seed[17] & seed[18]};
      lr = seed[23:20];
      lt = seed[27:24];
      ls = seed[30:28];
      peer_u.send(lr, lt, ls, ev, seed[31] ? 200 : 0);
      m_rx  = (lr > `SLSR_LANE_MAX) ? 0 : int'(lr);
      m_tx  = (lt > `SLSR_LANE_MAX) ? 0 : int'(lt);
      m_smp = int'(ls);
      m_stall = ev[5] ? 1 : (ev[4] ? 0 : m_stall);
      m_rerr  = ev[3] ? 1 : m_rerr;
      m_lerr  = ev[2] ? 1 : m_lerr;
      m_link  = ev[0] ? 0 : (ev[1] ? 1 : m_link);
      // the link word lands about four core clocks after the rise
      repeat (6) @(posedge core_clk_i);
      if (seed[19]) begin
        seed = rnd(seed);
        ahb(1'h1, `SLSR_OFF_STATUS, seed, rd);
        m_rerr = seed[8] ? 0 : m_rerr;
        m_lerr = seed[7] ? 0 : m_lerr;
      end
      seed = rnd(seed);
      if (seed[0]) begin
        ahb(1'h1, `SLSR_OFF_MASK, seed, rd);
        m_mask = int'(seed & 32'h0000_0180);
      end
      ahb(1'h0, `SLSR_OFF_STATUS, 32'h0, rd);
      check("status", rd, exp_status());
      ahb(1'h0, `SLSR_OFF_MASK, 32'h0, rd);
      check("mask", rd, 32'(m_mask));
      @(negedge core_clk_i);
      check("stall", {31'h0, tx_stall_o}, 32'(m_stall));
      check("outbound_flow_request", {31'h0, outbound_flow_request_o},
            {31'h0, fifo1_full_i | fifo2_full_i});
      check("irq", {31'h0, port_interrupt_o},
            32'((m_rerr & m_mask[8]) | (m_lerr & m_mask[7])));
    end
    end_of_test();
  end
endmodule
